// [rtl/mld_host.sv]
// Action record source: checks a software record and hands it to the decoder
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/10ps
module mld_host
  import mld_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  // Avalon-MM slave
  input  wire logic [4:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Record link
  mld_if.host              LINK
);

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} mld_hst_e;

  typedef struct packed {
    mld_hst_e    fsm;
    logic        issue;
    logic        ack;
    logic [31:0] rdata;
    logic        done;
    logic        refused;
    mld_action_s act;
    mld_stack_s  stk;
    mld_frame_s  frm;
    logic [31:0] pos;
    mld_result_s res;
  } mld_hst_s;

  mld_hst_s    st_ff;
  mld_hst_s    nxt_st;
  logic [31:0] wmask;
  logic        acc;
  logic        legal;
  mld_action_s a;

  assign wmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                  {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  // One access in flight; ack drops waitrequest for exactly one cycle
  assign acc   = (AVS_READ_I | AVS_WRITE_I) & ~st_ff.ack;
  assign a     = st_ff.act;

  //==============================================================
  // Record check
  always_comb begin
    legal = 1'b1;
    if ((a.forwarding_kind == FWD_PW_TERM) || (a.forwarding_kind == FWD_EXCHANGE) ||
        (a.forwarding_kind == FWD_REMOVE)) begin
      if (a.valid_label_depth > DEPTH_MAX) legal = 1'b0;
      if (a.next_offset == 8'h00) legal = 1'b0;
      if (!a.strip_headers_flag) legal = 1'b0;
    end
    case (mld_fwd_e'(a.forwarding_kind))
      FWD_NONE, FWD_CONTROL_PDU_FORWARD: begin
      end
      FWD_PW_TERM: begin
        if (a.next_header_kind == NH_MPLS) legal = 1'b0;
        if (a.oam_channel_kind > OAM_PW_MAX) legal = 1'b0;
      end
      FWD_EXCHANGE: begin
        if (a.next_header_kind != NH_MPLS) legal = 1'b0;
      end
      FWD_REMOVE: begin
        if (a.next_header_kind == NH_ETH) legal = 1'b0;
        if ((a.oam_channel_kind != 3'h0) && (a.oam_channel_kind != OAM_LSP_BELOW) &&
            (a.oam_channel_kind != OAM_LSP_AT)) legal = 1'b0;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  //==============================================================
  // Next state
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = acc;
    if (acc && AVS_READ_I) begin
      case (AVS_ADDRESS_I)
        REG_CTRL:   nxt_st.rdata = {29'h0, st_ff.refused, st_ff.done,
                                    st_ff.fsm != ST_IDLE};
        REG_ACTION: nxt_st.rdata = st_ff.act;
        REG_STACK:  nxt_st.rdata = st_ff.stk;
        REG_FRAME:  nxt_st.rdata = st_ff.frm;
        REG_POS:    nxt_st.rdata = st_ff.pos;
        REG_RESULT: nxt_st.rdata = st_ff.res;
        default:    nxt_st.rdata = 32'h0;
      endcase
    end
    // Record registers are frozen while a record is out on the link
    // Writes land at the edge that ends the wait, not when first seen
    if (st_ff.ack && AVS_WRITE_I && (st_ff.fsm == ST_IDLE)) begin
      case (AVS_ADDRESS_I)
        REG_CTRL: begin
          if (AVS_WRITEDATA_I[0] && AVS_BYTEENABLE_I[0]) begin
            nxt_st.done    = 1'b0;
            nxt_st.refused = !legal;
            nxt_st.fsm     = legal ? ST_ISSUE : ST_IDLE;
          end
        end
        REG_ACTION: nxt_st.act = (st_ff.act & ~wmask) | (AVS_WRITEDATA_I & wmask);
        REG_STACK:  nxt_st.stk = (st_ff.stk & ~wmask) | (AVS_WRITEDATA_I & wmask);
        REG_FRAME:  nxt_st.frm = (st_ff.frm & ~wmask) | (AVS_WRITEDATA_I & wmask);
        REG_POS:    nxt_st.pos = (st_ff.pos & ~wmask) | (AVS_WRITEDATA_I & wmask);
        default: begin
        end
      endcase
    end
    case (st_ff.fsm)
      ST_ISSUE: nxt_st.fsm = ST_WAIT;
      ST_WAIT: begin
        if (LINK.rsp_vld) begin
          nxt_st.res  = LINK.rsp;
          nxt_st.done = 1'b1;
          nxt_st.fsm  = ST_IDLE;
        end
      end
      default: begin
      end
    endcase
    // Request pulse kept in its own flop so the link sees no decode
    nxt_st.issue = (nxt_st.fsm == ST_ISSUE);
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //==============================================================
  // Outputs
  assign AVS_READDATA_O         = st_ff.rdata;
  assign AVS_WAITREQUEST_O      = ~st_ff.ack;
  assign LINK.req_vld           = st_ff.issue;
  assign LINK.tc_source_select  = a.tc_source_select;
  assign LINK.ttl_source_select = a.ttl_source_select;
  assign LINK.valid_label_depth = a.valid_label_depth;
  assign LINK.forwarding_kind   = a.forwarding_kind;
  assign LINK.oam_channel_kind  = a.oam_channel_kind;
  assign LINK.pdu_position_select = a.pdu_position_select;
  assign LINK.lse_cnt           = st_ff.stk.lse_cnt;
  assign LINK.lse_ttl           = st_ff.stk.lse_ttl;
  assign LINK.rsvd_seen         = st_ff.stk.rsvd_seen;
  assign LINK.lse_tc            = st_ff.frm.lse_tc;
  assign LINK.in_tc             = st_ff.frm.in_tc;
  assign LINK.in_ttl            = st_ff.frm.in_ttl;
  assign LINK.cur_pos           = st_ff.frm.cur_pos;
  assign LINK.eth_pos           = st_ff.pos[7:0];
  assign LINK.ip_pos            = st_ff.pos[15:8];
  assign LINK.norm_pos          = st_ff.pos[23:16];
  assign LINK.raw_pos           = st_ff.pos[31:24];

endmodule : mld_host

// [rtl/mld_pkg.sv]
// Constants, encodings and register layouts of the MPLS action decoder
//==============================================================
// Overview of operation
// - TC selector picks entry 0-2, 3 keeps
// - TTL selector picks entry 0-2, 3 keeps
// - Label depth counts from top, range 0-2
// - Skipped reserved labels excluded from depth count
// - Forwarding kind decoded: none, pw, swap, pop, control pdu
// - Kind none: no action, depth ignored
// - Pw: depth at pw label, offset set
// - Pw: next header cw or eth, strip set
// - Pw: channel kind limited to 0-4
// - Swap at depth, pop entries above it
// - Swap: offset, depth, strip, next header mpls
// - Swap: no oam detect, redirect allowed
// - Pop: offset past labels, depth, strip set
// - Pop: next header mpls, or cw
// - Pop: channel kind limited to 0, 5, 6
// - Control pdu: channel kind becomes pdu kind
// - Control pdu_position select keeps or repoints
// - Control pdu coded 4, bypasses post-processing
package mld_pkg;

  //==============================================================
  // Field widths and limits
  localparam int          TC_W          = 3;
  localparam int          TTL_W         = 8;
  localparam int          POS_W         = 8;
  localparam int          LSE_N         = 3;
  localparam logic [1:0]  DEPTH_MAX     = 2'h2;
  localparam logic [1:0]  SEL_KEEP      = 2'h3;
  localparam logic [7:0]  TTL_EXPIRE    = 8'h01;
  localparam logic [2:0]  OAM_PW_MAX    = 3'h4;
  localparam logic [2:0]  OAM_LSP_BELOW = 3'h5;
  localparam logic [2:0]  OAM_LSP_AT    = 3'h6;

  //==============================================================
  // Encodings
  typedef enum logic [3:0] {
    FWD_NONE     = 4'h0,
    FWD_PW_TERM  = 4'h1,
    FWD_EXCHANGE = 4'h2,
    FWD_REMOVE   = 4'h3,
    FWD_CONTROL_PDU_FORWARD = 4'h4
  } mld_fwd_e;

  typedef enum logic [1:0] {
    PSEL_KEEP = 2'h0,
    PSEL_ETH  = 2'h1,
    PSEL_IP   = 2'h2,
    PSEL_DIFF = 2'h3
  } mld_psel_e;

  typedef enum logic [1:0] {
    NH_ETH  = 2'h0,
    NH_CW   = 2'h1,
    NH_MPLS = 2'h2
  } mld_nh_e;

  //==============================================================
  // Register map, byte addresses
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_ACTION = 5'h04;
  localparam logic [4:0] REG_STACK  = 5'h08;
  localparam logic [4:0] REG_FRAME  = 5'h0C;
  localparam logic [4:0] REG_POS    = 5'h10;
  localparam logic [4:0] REG_RESULT = 5'h14;

  // Layouts, most significant field first
  typedef struct packed {
    logic [4:0] rsvd;
    logic       off_is32;
    logic [7:0] next_offset;
    logic [1:0] next_header_kind;
    logic       strip_headers_flag;
    logic [1:0] pdu_position_select;
    logic [2:0] oam_channel_kind;
    logic [3:0] forwarding_kind;
    logic [1:0] valid_label_depth;
    logic [1:0] ttl_source_select;
    logic [1:0] tc_source_select;
  } mld_action_s;

  typedef struct packed {
    logic [4:0]  rsvd;
    logic        rsvd_seen;
    logic [1:0]  lse_cnt;
    logic [23:0] lse_ttl;
  } mld_stack_s;

  typedef struct packed {
    logic [3:0] rsvd;
    logic [7:0] cur_pos;
    logic [7:0] in_ttl;
    logic [2:0] in_tc;
    logic [8:0] lse_tc;
  } mld_frame_s;

  typedef struct packed {
    logic       cfg_err;
    logic       bypass;
    logic [7:0] pdu_position;
    logic [2:0] pdu_kind;
    logic       cpu_redirect;
    logic       oam_detect;
    logic       pw_term;
    logic [1:0] swap_pos;
    logic       swap_en;
    logic [1:0] pop_cnt;
    logic [7:0] out_ttl;
    logic [2:0] out_tc;
  } mld_result_s;

endpackage : mld_pkg

// [rtl/mld_if.sv]
// Link between the action record source and the MPLS action decoder
`timescale 1ns/10ps
interface mld_if;
  import mld_pkg::*;

  // Record and frame facts, record source to decoder
  logic        req_vld;
  logic [1:0]  tc_source_select;
  logic [1:0]  ttl_source_select;
  logic [1:0]  valid_label_depth;
  logic [3:0]  forwarding_kind;
  logic [2:0]  oam_channel_kind;
  logic [1:0]  pdu_position_select;
  logic [1:0]  lse_cnt;
  logic [8:0]  lse_tc;
  logic [23:0] lse_ttl;
  logic [2:0]  in_tc;
  logic [7:0]  in_ttl;
  logic        rsvd_seen;
  logic [7:0]  cur_pos;
  logic [7:0]  eth_pos;
  logic [7:0]  ip_pos;
  logic [7:0]  norm_pos;
  logic [7:0]  raw_pos;
  // Decoded result, decoder to record source
  logic        rsp_vld;
  mld_result_s rsp;

  modport dev (
    input  req_vld, tc_source_select, ttl_source_select, valid_label_depth,
    input  forwarding_kind, oam_channel_kind, pdu_position_select, lse_cnt,
    input  lse_tc, lse_ttl, in_tc, in_ttl, rsvd_seen, cur_pos, eth_pos,
    input  ip_pos, norm_pos, raw_pos,
    output rsp_vld, rsp
  );

  modport host (
    output req_vld, tc_source_select, ttl_source_select, valid_label_depth,
    output forwarding_kind, oam_channel_kind, pdu_position_select, lse_cnt,
    output lse_tc, lse_ttl, in_tc, in_ttl, rsvd_seen, cur_pos, eth_pos,
    output ip_pos, norm_pos, raw_pos,
    input  rsp_vld, rsp
  );
endinterface : mld_if

// [rtl/mld_lse_pick.sv]
// Picks one field from the compacted label stack, or keeps the current value
`timescale 1ns/10ps
module mld_lse_pick
  import mld_pkg::*;
#(
  parameter int W = 3
) (
  // Selection
  input  wire logic [1:0]       sel_i,
  input  wire logic [1:0]       cnt_i,
  // Values
  input  wire logic [3*W-1:0]   flds_i,
  input  wire logic [W-1:0]     cur_i,
  output logic      [W-1:0]     val_o
);

  //==============================================================
  // Selection
  always_comb begin
    if (sel_i == SEL_KEEP) begin
      val_o = cur_i;
    end else if (sel_i >= cnt_i) begin
      val_o = cur_i;
    end else begin
      val_o = flds_i[sel_i*W +: W];
    end
  end

endmodule : mld_lse_pick

// [rtl/mld_decode.sv]
// MPLS action decoder: device end of the action record link
`timescale 1ns/10ps
module mld_decode
  import mld_pkg::*;
(
  // Clock and reset
  input  wire logic MCLK_I,
  input  wire logic RST_I,
  // Record link
  mld_if.dev        LINK
);

  //==============================================================
  // State
  typedef struct packed {
    logic        rsp_vld;
    mld_result_s rsp;
  } mld_dev_s;

  mld_dev_s          st_ff;
  mld_dev_s          nxt_st;
  logic [TC_W-1:0]   tc_pick;
  logic [TTL_W-1:0]  ttl_pick;
  logic              depth_ok;
  logic [1:0]        depth_inc;
  logic              ttl_dead;
  logic [POS_W-1:0]  pos_diff;
  mld_fwd_e          fwd;

  //==============================================================
  // Label stack selection
  // The stack arrives compacted: skipped reserved labels are already
  // removed, so entry numbers and the depth count agree.
  mld_lse_pick #(
    .W      (TC_W)
  ) u_tc_pick (
    .sel_i  (LINK.tc_source_select),
    .cnt_i  (LINK.lse_cnt),
    .flds_i (LINK.lse_tc),
    .cur_i  (LINK.in_tc),
    .val_o  (tc_pick)
  );

  mld_lse_pick #(
    .W      (TTL_W)
  ) u_ttl_pick (
    .sel_i  (LINK.ttl_source_select),
    .cnt_i  (LINK.lse_cnt),
    .flds_i (LINK.lse_ttl),
    .cur_i  (LINK.in_ttl),
    .val_o  (ttl_pick)
  );

  //==============================================================
  // Helpers
  assign fwd = mld_fwd_e'(LINK.forwarding_kind);

  // Depth must lie in range and name a present, non-reserved entry
  assign depth_ok = (LINK.valid_label_depth <= DEPTH_MAX) &&
                    (LINK.valid_label_depth < LINK.lse_cnt);

  // Entries from the top down to and including the depth entry
  assign depth_inc = 2'(LINK.valid_label_depth + 2'h1);

  // Expiry judged on the TTL this frame is classified with
  assign ttl_dead = (ttl_pick <= TTL_EXPIRE);

  // Wraps on purpose if the raw payload lies after the normalized one
  assign pos_diff = 8'(LINK.norm_pos - LINK.raw_pos);

  //==============================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp_vld = 1'b0;
    if (LINK.req_vld) begin
      nxt_st.rsp_vld           = 1'b1;
      nxt_st.rsp               = '0;
      nxt_st.rsp.out_tc        = tc_pick;
      nxt_st.rsp.out_ttl       = ttl_pick;
      nxt_st.rsp.pdu_position  = LINK.cur_pos;
      case (fwd)
        FWD_NONE: begin
          // Depth field is not looked at here
          nxt_st.rsp.pop_cnt   = 2'h0;
        end
        FWD_PW_TERM: begin
          if (depth_ok) begin
            nxt_st.rsp.pw_term    = 1'b1;
            nxt_st.rsp.pop_cnt    = depth_inc;
            nxt_st.rsp.oam_detect = (LINK.oam_channel_kind != 3'h0);
          end else begin
            nxt_st.rsp.cfg_err    = 1'b1;
          end
        end
        FWD_EXCHANGE: begin
          if (depth_ok) begin
            nxt_st.rsp.swap_en    = 1'b1;
            nxt_st.rsp.swap_pos   = LINK.valid_label_depth;
            nxt_st.rsp.pop_cnt    = LINK.valid_label_depth;
            nxt_st.rsp.oam_detect = 1'b0;
            nxt_st.rsp.cpu_redirect = LINK.rsvd_seen |
                                      ttl_dead;
          end else begin
            nxt_st.rsp.cfg_err    = 1'b1;
          end
        end
        FWD_REMOVE: begin
          if (depth_ok) begin
            nxt_st.rsp.pop_cnt    = depth_inc;
            nxt_st.rsp.oam_detect =
              (LINK.oam_channel_kind == OAM_LSP_BELOW) ||
              (LINK.oam_channel_kind == OAM_LSP_AT);
          end else begin
            nxt_st.rsp.cfg_err    = 1'b1;
          end
        end
        FWD_CONTROL_PDU_FORWARD: begin
          nxt_st.rsp.bypass   = 1'b1;
          nxt_st.rsp.pdu_kind = LINK.oam_channel_kind;
          case (mld_psel_e'(LINK.pdu_position_select))
            PSEL_KEEP: begin
              nxt_st.rsp.pdu_position = LINK.cur_pos;
            end
            PSEL_ETH: begin
              nxt_st.rsp.pdu_position = LINK.eth_pos;
            end
            PSEL_IP: begin
              nxt_st.rsp.pdu_position = LINK.ip_pos;
            end
            PSEL_DIFF: begin
              nxt_st.rsp.pdu_position = pos_diff;
            end
            default: begin
              nxt_st.rsp.pdu_position = LINK.cur_pos;
            end
          endcase
        end
        default: begin
          // Unused codes: flag the record, leave the frame alone
          nxt_st.rsp.cfg_err = 1'b1;
        end
      endcase
    end
  end

  //==============================================================
  // Registers
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //==============================================================
  // Outputs
  assign LINK.rsp_vld = st_ff.rsp_vld;
  assign LINK.rsp     = st_ff.rsp;

endmodule : mld_decode

// [tb/mld_link_properties.sv]
// Concurrent checks on the record link between host and decoder
`timescale 1ns/10ps
module mld_link_properties
  import mld_pkg::*;
(
  // Clock and reset
  input wire logic        MCLK_I,
  input wire logic        RST_I,
  // Record
  input wire logic        req_vld,
  input wire logic [1:0]  tc_source_select,
  input wire logic [1:0]  ttl_source_select,
  input wire logic [1:0]  valid_label_depth,
  input wire logic [3:0]  forwarding_kind,
  input wire logic [2:0]  oam_channel_kind,
  input wire logic [1:0]  pdu_position_select,
  input wire logic [1:0]  lse_cnt,
  input wire logic [8:0]  lse_tc,
  input wire logic [23:0] lse_ttl,
  input wire logic [2:0]  in_tc,
  input wire logic [7:0]  in_ttl,
  input wire logic [7:0]  cur_pos,
  input wire logic [7:0]  eth_pos,
  input wire logic [7:0]  ip_pos,
  input wire logic [7:0]  norm_pos,
  input wire logic [7:0]  raw_pos,
  // Result
  input wire logic        rsp_vld,
  input wire mld_result_s rsp
);
  //==============================================================
  // Helpers
  logic [7:0] exp_pos;
  logic       kind_act;
  logic [2:0] tc_entry;
  logic [7:0] ttl_entry;
  assign tc_entry  = lse_tc[3*tc_source_select +: 3];
  assign ttl_entry = lse_ttl[8*ttl_source_select +: 8];
  assign exp_pos = (pdu_position_select == PSEL_KEEP) ? cur_pos :
                   (pdu_position_select == PSEL_ETH) ? eth_pos :
                   (pdu_position_select == PSEL_IP) ? ip_pos : norm_pos - raw_pos;
  assign kind_act = forwarding_kind inside {FWD_PW_TERM, FWD_EXCHANGE, FWD_REMOVE};

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  //==============================================================
  // Assertions
  a_rsp_single: assert property (req_vld |=> rsp_vld ##1 !rsp_vld)
    else $error("response pulse missing or too long");
  a_rsp_caused: assert property ($rose(rsp_vld) |-> $past(req_vld))
    else $error("response without a record");
  a_tc_entry: assert property (req_vld && tc_source_select != SEL_KEEP
    && tc_source_select < lse_cnt |=> rsp.cfg_err
    || rsp.out_tc == $past(tc_entry))
    else $error("tc not taken from selected entry");
  a_tc_kept: assert property (req_vld && (tc_source_select == SEL_KEEP
    || tc_source_select >= lse_cnt) |=> rsp.cfg_err || rsp.out_tc == $past(in_tc))
    else $error("tc changed without an entry");
  a_ttl_entry: assert property (req_vld && ttl_source_select != SEL_KEEP
    && ttl_source_select < lse_cnt |=> rsp.cfg_err
    || rsp.out_ttl == $past(ttl_entry))
    else $error("ttl not taken from selected entry");
  a_none_quiet: assert property (req_vld && forwarding_kind == FWD_NONE
    |=> !rsp.pw_term && !rsp.swap_en && rsp.pop_cnt == 2'h0 && !rsp.cfg_err)
    else $error("label action for kind none");
  a_swap_depth: assert property (req_vld && forwarding_kind == FWD_EXCHANGE
    |=> rsp.cfg_err || (rsp.swap_en && !rsp.oam_detect
    && rsp.swap_pos == $past(valid_label_depth) && rsp.pop_cnt == $past(valid_label_depth)))
    else $error("swap position or pops wrong");
  a_pop_depth: assert property (req_vld && (forwarding_kind == FWD_REMOVE
    || forwarding_kind == FWD_PW_TERM)
    |=> rsp.cfg_err || rsp.pop_cnt == $past(valid_label_depth) + 2'h1)
    else $error("pop count wrong");
  a_depth_err: assert property (req_vld && kind_act && (valid_label_depth > DEPTH_MAX
    || valid_label_depth >= lse_cnt) |=> rsp.cfg_err && !rsp.swap_en && !rsp.pw_term)
    else $error("bad depth not flagged");
  a_ctrl_kind: assert property (req_vld && forwarding_kind == FWD_CONTROL_PDU_FORWARD
    |=> rsp.bypass && rsp.pdu_kind == $past(oam_channel_kind))
    else $error("control pdu kind wrong");
  a_ctrl_offset: assert property (req_vld && forwarding_kind == FWD_CONTROL_PDU_FORWARD
    |=> rsp.pdu_position == $past(exp_pos))
    else $error("control pdu position wrong");

  c_swap: cover property (req_vld && forwarding_kind == FWD_EXCHANGE);
  c_diff: cover property (req_vld && forwarding_kind == FWD_CONTROL_PDU_FORWARD
    && pdu_position_select == PSEL_DIFF);
  c_err: cover property (rsp_vld && rsp.cfg_err);
endmodule : mld_link_properties

// [tb/mld_decode_bench.sv]
// Self-checking bench: host and decoder joined, driven over Avalon-MM
`timescale 1ns/10ps
module mld_decode_bench;
  import mld_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [31:0] rdat;
  logic        wreq;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          n_req = 0;
  int          seed = 30977;
  mld_if link ();

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (link.req_vld === 1'b1) n_req <= n_req + 1;

  mld_decode i_mld_decode (.MCLK_I(mclk), .RST_I(rst), .LINK(link.dev));
  mld_host i_mld_host (.MCLK_I(mclk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_en),
    .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .LINK(link.host));
  mld_link_properties i_mld_link_properties (.MCLK_I(mclk), .RST_I(rst),
    .req_vld(link.req_vld), .tc_source_select(link.tc_source_select),
    .ttl_source_select(link.ttl_source_select), .valid_label_depth(link.valid_label_depth),
    .forwarding_kind(link.forwarding_kind), .oam_channel_kind(link.oam_channel_kind),
    .pdu_position_select(link.pdu_position_select), .lse_cnt(link.lse_cnt),
    .lse_tc(link.lse_tc), .lse_ttl(link.lse_ttl), .in_tc(link.in_tc), .in_ttl(link.in_ttl),
    .cur_pos(link.cur_pos), .eth_pos(link.eth_pos), .ip_pos(link.ip_pos),
    .norm_pos(link.norm_pos), .raw_pos(link.raw_pos), .rsp_vld(link.rsp_vld), .rsp(link.rsp));

  //==============================================================
  // Reporting
  task automatic give_verdict;
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  //==============================================================
  // Avalon master: one transfer, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    adr <= a;
    wdat <= d;
    be <= b;
    wr_en <= wr;
    rd_en <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (wreq !== 1'b0) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : av

  //==============================================================
  // Record generation and expectation
  task automatic mk(input logic [3:0] k, output logic [31:0] a, s, f, p);
    logic [1:0] dep;
    logic [1:0] cnt;
    logic [2:0] oam;
    logic [1:0] nh;
    int         r;
    r = {$random(seed)} % 3;
    dep = 2'(r);
    cnt = 2'({$random(seed)} % 4);
    // Active kinds need the depth inside the stack
    if (k inside {FWD_PW_TERM, FWD_EXCHANGE, FWD_REMOVE}) begin
      cnt = 2'(r + 1 + {$random(seed)} % (3 - r));
    end
    r = {$random(seed)} % 5;
    oam = (k == FWD_CONTROL_PDU_FORWARD) ? 3'($random(seed)) : 3'h0;
    if (k == FWD_PW_TERM) oam = 3'(r);
    if (k == FWD_REMOVE) oam = (r < 2) ? 3'h0 : (r < 4) ? OAM_LSP_BELOW : OAM_LSP_AT;
    nh = (k == FWD_PW_TERM) ? NH_CW : NH_MPLS;
    if (k == FWD_NONE || k == FWD_CONTROL_PDU_FORWARD) nh = NH_ETH;
    a = {5'h00, 1'b0, 8'h04, nh, 1'b1, 2'($random(seed)), oam, k, dep, 4'($random(seed))};
    s = {5'h00, 27'($random(seed))};
    s[25:24] = cnt;
    f = {4'h0, 28'($random(seed))};
    p = $random(seed);
  endtask : mk

  function automatic mld_result_s exp_res(input logic [31:0] a, s, f, p);
    mld_result_s r;
    logic [1:0]  dep;
    logic [1:0]  cnt;
    logic [3:0]  k;
    r = '0;
    dep = a[5:4];
    k = a[9:6];
    cnt = s[25:24];
    r.out_tc = (a[1:0] != SEL_KEEP && a[1:0] < cnt) ? f[3*a[1:0] +: 3] : f[11:9];
    r.out_ttl = (a[3:2] != SEL_KEEP && a[3:2] < cnt) ? s[8*a[3:2] +: 8] : f[19:12];
    r.pdu_position = f[27:20];
    r.cfg_err = (k inside {FWD_PW_TERM, FWD_EXCHANGE, FWD_REMOVE}) && dep >= cnt;
    if (!r.cfg_err) begin
      r.pw_term = (k == FWD_PW_TERM);
      r.swap_en = (k == FWD_EXCHANGE);
      r.swap_pos = r.swap_en ? dep : 2'h0;
      r.pop_cnt = (k == FWD_PW_TERM || k == FWD_REMOVE) ? dep + 2'h1 : r.swap_pos;
      r.oam_detect = (k == FWD_PW_TERM) ? (a[12:10] != 3'h0) :
                     ((k == FWD_REMOVE) && (a[12:10] inside {OAM_LSP_BELOW, OAM_LSP_AT}));
      r.cpu_redirect = r.swap_en && (s[26] || r.out_ttl <= TTL_EXPIRE);
    end
    if (k == FWD_CONTROL_PDU_FORWARD) begin
      r.bypass = 1'b1;
      r.pdu_kind = a[12:10];
      r.pdu_position = (a[14:13] == PSEL_KEEP) ? f[27:20] : (a[14:13] == PSEL_ETH) ? p[7:0] :
                       (a[14:13] == PSEL_IP) ? p[15:8] : p[23:16] - p[31:24];
    end
    return r;
  endfunction : exp_res

  // Loads one record, starts it and checks what comes back
  task automatic run(input logic [31:0] a, s, f, p, input logic bad);
    logic [31:0] q;
    mld_result_s e;
    int          n;
    int          r0;
    r0 = n_req;
    av(1'b1, REG_ACTION, a, 4'hF, q);
    av(1'b1, REG_STACK, s, 4'hF, q);
    av(1'b1, REG_FRAME, f, 4'hF, q);
    av(1'b1, REG_POS, p, 4'hF, q);
    av(1'b1, REG_CTRL, 32'h1, 4'hF, q);
    n = 0;
    do begin
      av(1'b0, REG_CTRL, 32'h0, 4'hF, q);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    if (q[0] !== 1'b0) begin
      n_mismatch++;
      give_verdict();
    end
    chk("refused", {31'h0, bad}, {31'h0, q[2]});
    chk("records sent", 32'(r0 + (bad ? 0 : 1)), 32'(n_req));
    if (!bad) begin
      e = exp_res(a, s, f, p);
      av(1'b0, REG_RESULT, 32'h0, 4'hF, q);
      chk("result", e, q);
    end
  endtask : run

  //==============================================================
  // Main sequence
  initial begin
    logic [31:0] a, s, f, p, q;
    int          r0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    av(1'b0, REG_CTRL, 32'h0, 4'hF, q);
    chk("control after reset", 32'h0, q);
    av(1'b0, REG_RESULT, 32'h0, 4'hF, q);
    chk("result after reset", 32'h0, q);
    av(1'b0, 5'h18, 32'h0, 4'hF, q);
    chk("unmapped read", 32'h0, q);
    for (int k = 0; k < 5; k++) begin
      repeat (4) begin
        mk(4'(k), a, s, f, p);
        run(a, s, f, p, 1'b0);
      end
    end
    // Every pdu kind and offset select
    for (int i = 0; i < 8; i++) begin
      mk(FWD_CONTROL_PDU_FORWARD, a, s, f, p);
      a[14:10] = {2'(i), 3'(i)};
      run(a, s, f, p, 1'b0);
    end
    // Depth names an entry the stack lacks
    mk(FWD_EXCHANGE, a, s, f, p);
    a[5:4] = 2'h1;
    s[25:24] = 2'h1;
    run(a, s, f, p, 1'b0);
    // Selectors point into an empty stack
    mk(FWD_NONE, a, s, f, p);
    a[3:0] = 4'h0;
    s[25:24] = 2'h0;
    run(a, s, f, p, 1'b0);
    // Deepest allowed swap
    mk(FWD_EXCHANGE, a, s, f, p);
    a[5:4] = DEPTH_MAX;
    s[25:24] = 2'h3;
    // Expired TTL alone must send the frame to the cpu
    s[26] = 1'b0;
    a[3:2] = 2'h0;
    s[7:0] = TTL_EXPIRE;
    run(a, s, f, p, 1'b0);
    // Records the host must refuse
    mk(FWD_NONE, a, s, f, p);
    a[9:6] = 4'h5;
    run(a, s, f, p, 1'b1);
    mk(FWD_PW_TERM, a, s, f, p);
    a[12:10] = OAM_LSP_BELOW;
    run(a, s, f, p, 1'b1);
    // Start bit without its byte lane
    r0 = n_req;
    av(1'b1, REG_CTRL, 32'h1, 4'hE, q);
    repeat (3) @(posedge mclk);
    chk("masked start", 32'(r0), 32'(n_req));
    repeat (40) begin
      mk(4'({$random(seed)} % 5), a, s, f, p);
      run(a, s, f, p, 1'b0);
    end
    give_verdict();
  end
endmodule : mld_decode_bench
